// File: rtl/uoh_defines.vh
/*
  Offsets, values, flag masks and timing of the USB host sequencer.
  Assumes plain Verilog-2005 and a 20 MHz clock.
*/
`ifndef UOH_DEFINES_VH
`define UOH_DEFINES_VH

// Own APB registers, byte addresses
`define UOH_CMD_OFS 12'h000
`define UOH_CFG_OFS 12'h004
`define UOH_BUF_OFS 12'h008
`define UOH_STAT_OFS 12'h00c

// Command codes written to the command register
`define UOH_OP_WATCH 3'h0
`define UOH_OP_SETUP 3'h1
`define UOH_OP_IN 3'h2
`define UOH_OP_STATUS 3'h3
`define UOH_OP_BULK 3'h4
`define UOH_OP_SRP 3'h5

// Offsets on the module's own register port
`define UOH_DEV_OTG_FLAGS 12'h000
`define UOH_DEV_TOP_FLAGS 12'h004
`define UOH_DEV_OTG_CON 12'h008
`define UOH_DEV_CFG_TWO 12'h00c
`define UOH_DEV_EP_ZERO 12'h010
`define UOH_DEV_TARGET 12'h014
`define UOH_DEV_TOKEN 12'h018
`define UOH_DEV_BD_STAT 12'h020
`define UOH_DEV_BD_PTR 12'h024

// Endpoint-zero control values and bits
`define UOH_EP0_CONTROL 8'h0d
`define UOH_EP0_BULK 8'h1d
`define UOH_EP0_LOW_SPEED_SELECT_BIT 7
`define UOH_EP0_RETRY_BIT 6

// Descriptor status words and fields
`define UOH_BD_SETUP8 16'h8008
`define UOH_BD_DATA1_64 16'hc040
`define UOH_BD_ZLP_DATA0 16'h8000
`define UOH_BD_TOGGLE_BIT 14
`define UOH_BD_PID_LSB 2
`define UOH_PID_ERROR 4'hf

// Token register values
`define UOH_TOK_SETUP 8'hd0
`define UOH_TOK_IN 8'h90
`define UOH_TOK_OUT_PID 4'h1

// Flag masks in the module's flag registers
`define UOH_TOP_DETACH 8'h01
`define UOH_TOP_TOKDONE 8'h08
`define UOH_TOP_ATTACH 8'h40
`define UOH_OTG_SESEND 8'h04
`define UOH_OTG_SESVALID 8'h08

// Line control values
`define UOH_OTGCON_DISCHARGE 8'h01
`define UOH_OTGCON_DPLUS_UP 8'h80
`define UOH_CFG2_VBUS_PULSE 8'h10

// Timing: figures in microseconds and derived cycle counts
`define UOH_CLK_MHZ 20
`define UOH_FRAME_US 1000
`define UOH_LINES_LOW_US 2000
`define UOH_DPULSE_US 7500
`define UOH_VBUS_PULSE_US 10000
`define UOH_FRAME_CYC (`UOH_FRAME_US * `UOH_CLK_MHZ)
`define UOH_LINES_LOW_CYC (`UOH_LINES_LOW_US * `UOH_CLK_MHZ)
`define UOH_DPULSE_CYC (`UOH_DPULSE_US * `UOH_CLK_MHZ)
`define UOH_VBUS_PULSE_CYC (`UOH_VBUS_PULSE_US * `UOH_CLK_MHZ)

`endif

// File: rtl/uoh_dev_master.v
/*
  One APB transfer at a time on the module's register port.
  Assumes start is a one-cycle pulse given only while no transfer is open.
*/
module uoh_dev_master (
  input wire pclk,
  input wire presetn,
  input wire start,
  input wire [11:0] addr,
  input wire write,
  input wire [31:0] wdata,
  output reg done,
  output reg [31:0] rdata,
  output reg m_psel,
  output reg m_penable,
  output reg m_pwrite,
  output reg [11:0] m_paddr,
  output reg [31:0] m_pwdata,
  input wire [31:0] m_prdata,
  input wire m_pready
);

  // Setup cycle, then access held until pready; no timeout, the slave decides
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done <= 1'b0;
      rdata <= 32'h0;
      m_psel <= 1'b0;
      m_penable <= 1'b0;
      m_pwrite <= 1'b0;
      m_paddr <= 12'h0;
      m_pwdata <= 32'h0;
    end else begin
      done <= 1'b0;
      if (!m_psel && start) begin
        // Request is frozen from here until the accepting edge
        m_psel <= 1'b1;
        m_paddr <= addr;
        m_pwrite <= write;
        m_pwdata <= wdata;
      end else if (m_psel && !m_penable) begin
        m_penable <= 1'b1;
      end else if (m_penable && m_pready) begin
        // Read data taken only at the accepting edge
        m_psel <= 1'b0;
        m_penable <= 1'b0;
        done <= 1'b1;
        if (!m_pwrite) begin
          rdata <= m_prdata;
        end
      end
    end
  end

endmodule // uoh_dev_master

// File: rtl/uoh_host_seq.v
/*
  Host-mode sequencer for a USB OTG module.
  Runs SETUP, IN, status OUT, bulk OUT and
  session requests ordered over APB, programs
  the module over its register port and
  reports the returned handshake.
  Assumes an APB register port on the module
  with descriptor words at fixed offsets.
*/
// Added by the designer: the address map and register access over APB.
// Operation
// - Control transfers write 0Dh to endpoint control
// - Setup descriptor word 8008h, eight bytes
// - Seven-bit target address for every token
// - Data phase descriptor C040h, DATA1, 64 bytes
// - Status descriptor 8000h, DATA0, zero count
// - One control transaction per USB frame
// - Bulk transfers write 1Dh to endpoint control
// - Endpoint control bit 7 selects low speed
// - Software checks data lines low 2 ms; the sequencer only waits 2 ms and does not measure them
// - D+ pull-up pulse held 5 to 10 ms
// - Config-two bit 4 pulses VBUS, unmonitored
`include "uoh_defines.vh"

module uoh_host_seq #(
  parameter [23:0] FRAME_CYC = `UOH_FRAME_CYC,
  parameter [23:0] LINES_LOW_CYC = `UOH_LINES_LOW_CYC,
  parameter [23:0] DPULSE_CYC = `UOH_DPULSE_CYC,
  parameter [23:0] VBUS_PULSE_CYC = `UOH_VBUS_PULSE_CYC
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire m_psel,
  output wire m_penable,
  output wire m_pwrite,
  output wire [11:0] m_paddr,
  output wire [31:0] m_pwdata,
  input wire [31:0] m_prdata,
  input wire m_pready
);

  // Sequencer states
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_FETCH = 2'd1;
  localparam [1:0] ST_BUS = 2'd2;
  localparam [1:0] ST_TIME = 2'd3;

  // Micro-step actions
  localparam [2:0] A_WR = 3'd0;
  localparam [2:0] A_POLL = 3'd1;
  localparam [2:0] A_BDRD = 3'd2;
  localparam [2:0] A_DLY = 3'd3;
  localparam [2:0] A_END = 3'd4;

  // Software registers
  reg [6:0] target_addr; // Target address
  reg low_speed_select; // Low-speed target
  reg nak_retry_disable; // Report NAK instead of retrying
  reg [3:0] bulk_endpoint; // Endpoint of bulk OUT
  reg bulk_toggle; // DATA1 for bulk OUT when set
  reg [9:0] bulk_count; // Bulk OUT byte count
  reg [31:0] descriptor_buffer_pointer; // Buffer pointer for the descriptor
  reg cmd_pend; // Accepted order waiting for its frame
  reg [2:0] cmd_op; // Accepted order
  reg done_flag; // Order finished, sticky
  reg detach_seen; // Detach seen, sticky
  reg attach_seen; // Attach seen, sticky
  reg sesend_seen; // Session end seen, sticky
  reg sesvalid_seen; // Session valid seen, sticky
  reg aborted; // Last order ended by detach
  reg [3:0] last_pid; // Handshake of the last token

  // Sequencer state
  reg [1:0] state;
  reg [2:0] op; // Running micro-program
  reg [3:0] seq; // Step inside it
  reg running; // A software order is running
  reg clr_phase; // Write-one clear of a poll in flight
  reg [23:0] tmr; // Delay counter
  reg [23:0] frame_cnt; // Frame timer
  reg frame_used; // Control transaction spent this frame

  // Bus master request
  reg mst_start;
  reg [11:0] mst_addr;
  reg mst_write;
  reg [31:0] mst_wdata;
  wire mst_done;
  wire [31:0] mst_rdata;

  // Micro-step decode
  reg [2:0] r_act;
  reg [11:0] r_addr;
  reg [15:0] r_data;
  reg [7:0] ep0_val;
  reg [15:0] bd_val;
  reg [7:0] tok_val;

  wire wr_en = psel && penable && pwrite;
  wire mapped = (paddr == `UOH_CMD_OFS) || (paddr == `UOH_CFG_OFS) ||
                (paddr == `UOH_BUF_OFS) || (paddr == `UOH_STAT_OFS);
  wire ctl_op = (cmd_op == `UOH_OP_SETUP) || (cmd_op == `UOH_OP_IN) ||
                (cmd_op == `UOH_OP_STATUS);
  wire [7:0] masked = mst_rdata[7:0] & r_data[15:8];
  wire frame_tick = (frame_cnt == 24'h0);

  // Register port answers at once; unmapped words flag an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Per-order values for the shared token program
  always @* begin
    ep0_val = (op == `UOH_OP_BULK) ? `UOH_EP0_BULK : `UOH_EP0_CONTROL;
    ep0_val[`UOH_EP0_LOW_SPEED_SELECT_BIT] = low_speed_select;
    ep0_val[`UOH_EP0_RETRY_BIT] = nak_retry_disable;
    case (op)
      `UOH_OP_SETUP: begin
        bd_val = `UOH_BD_SETUP8;
        tok_val = `UOH_TOK_SETUP;
      end
      `UOH_OP_IN: begin
        bd_val = `UOH_BD_DATA1_64;
        tok_val = `UOH_TOK_IN;
      end
      `UOH_OP_STATUS: begin
        bd_val = `UOH_BD_ZLP_DATA0;
        tok_val = {`UOH_TOK_OUT_PID, 4'h0} >> 4;
      end
      default: begin
        // Bulk OUT owns the descriptor with the chosen toggle and count
        bd_val = {`UOH_BD_ZLP_DATA0 | {1'b0, bulk_toggle, 14'h0}} | {6'h0, bulk_count};
        tok_val = {bulk_endpoint, `UOH_TOK_OUT_PID};
      end
    endcase
  end

  // Micro-program: action, device offset, data (poll mask in data[15:8])
  always @* begin
    r_act = A_END;
    r_addr = 12'h0;
    r_data = 16'h0;
    if (op == `UOH_OP_WATCH) begin
      // Idle watch of the module's event flags
      case (seq)
        4'd0: begin
          r_act = A_POLL;
          r_addr = `UOH_DEV_TOP_FLAGS;
          r_data = {`UOH_TOP_DETACH | `UOH_TOP_ATTACH, 8'h0};
        end
        4'd1: begin
          r_act = A_POLL;
          r_addr = `UOH_DEV_OTG_FLAGS;
          r_data = {`UOH_OTG_SESEND | `UOH_OTG_SESVALID, 8'h0};
        end
        default: r_act = A_END;
      endcase
    end else if (op == `UOH_OP_SRP) begin
      // Session request; the 2 ms line check is waited out, not measured
      case (seq)
        4'd0: begin
          r_act = A_WR;
          r_addr = `UOH_DEV_OTG_CON;
          r_data = {8'h0, `UOH_OTGCON_DISCHARGE};
        end
        4'd1: begin
          r_act = A_POLL;
          r_addr = `UOH_DEV_OTG_FLAGS;
          r_data = {`UOH_OTG_SESEND, 8'h1};
        end
        4'd2: begin
          r_act = A_WR;
          r_addr = `UOH_DEV_OTG_CON;
        end
        4'd3: begin
          r_act = A_DLY;
          r_data = 16'h0000;
        end
        4'd4: begin
          r_act = A_WR;
          r_addr = `UOH_DEV_OTG_CON;
          r_data = {8'h0, `UOH_OTGCON_DPLUS_UP};
        end
        4'd5: begin
          r_act = A_DLY;
          r_data = 16'h0001;
        end
        4'd6: begin
          r_act = A_WR;
          r_addr = `UOH_DEV_OTG_CON;
        end
        4'd7: begin
          r_act = A_WR;
          r_addr = `UOH_DEV_CFG_TWO;
          r_data = {8'h0, `UOH_CFG2_VBUS_PULSE};
        end
        4'd8: begin
          r_act = A_DLY;
          r_data = 16'h0002;
        end
        4'd9: begin
          r_act = A_WR;
          r_addr = `UOH_DEV_CFG_TWO;
        end
        4'd10: begin
          r_act = A_POLL;
          r_addr = `UOH_DEV_OTG_FLAGS;
          r_data = {`UOH_OTG_SESVALID, 8'h1};
        end
        4'd11: begin
          r_act = A_WR;
          r_addr = `UOH_DEV_OTG_CON;
          r_data = {8'h0, `UOH_OTGCON_DPLUS_UP};
        end
        default: r_act = A_END;
      endcase
    end else begin
      // Token program shared by SETUP, IN, status OUT and bulk OUT
      case (seq)
        4'd0: begin
          r_act = A_WR;
          r_addr = `UOH_DEV_EP_ZERO;
          r_data = {8'h0, ep0_val};
        end
        4'd1: begin
          r_act = A_WR;
          r_addr = `UOH_DEV_BD_PTR;
          r_data = descriptor_buffer_pointer[15:0];
        end
        4'd2: begin
          r_act = A_WR;
          r_addr = `UOH_DEV_BD_STAT;
          r_data = bd_val;
        end
        4'd3: begin
          r_act = A_WR;
          r_addr = `UOH_DEV_TARGET;
          r_data = {8'h0, low_speed_select, target_addr};
        end
        4'd4: begin
          r_act = A_WR;
          r_addr = `UOH_DEV_TOKEN;
          r_data = {8'h0, tok_val};
        end
        4'd5: begin
          r_act = A_POLL;
          r_addr = `UOH_DEV_TOP_FLAGS;
          r_data = {`UOH_TOP_TOKDONE | `UOH_TOP_DETACH, 8'h1};
        end
        4'd6: begin
          r_act = A_BDRD;
          r_addr = `UOH_DEV_BD_STAT;
        end
        default: r_act = A_END;
      endcase
    end
  end

  // Software register writes and the pending order; a dispatch clear beats a new order
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target_addr <= 7'h0;
      low_speed_select <= 1'b0;
      nak_retry_disable <= 1'b0;
      bulk_endpoint <= 4'h0;
      bulk_toggle <= 1'b0;
      bulk_count <= 10'h0;
      descriptor_buffer_pointer <= 32'h0;
      cmd_pend <= 1'b0;
      cmd_op <= 3'h0;
    end else begin
      if (wr_en && paddr == `UOH_CFG_OFS) begin
        target_addr <= pwdata[6:0];
        low_speed_select <= pwdata[7];
        nak_retry_disable <= pwdata[8];
        bulk_endpoint <= pwdata[12:9];
        bulk_toggle <= pwdata[13];
        bulk_count <= pwdata[25:16];
      end
      if (wr_en && paddr == `UOH_BUF_OFS) begin
        descriptor_buffer_pointer <= pwdata;
      end
      if (state == ST_IDLE && cmd_pend && !(ctl_op && frame_used)) begin
        cmd_pend <= 1'b0;
      end else if (wr_en && paddr == `UOH_CMD_OFS && !running && !cmd_pend &&
                   pwdata[2:0] != `UOH_OP_WATCH && pwdata[2:0] <= `UOH_OP_SRP) begin
        // Orders that arrive while one is queued or running are dropped
        cmd_pend <= 1'b1;
        cmd_op <= pwdata[2:0];
      end
    end
  end

  // Read data registered in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable) begin
      case (paddr)
        `UOH_CMD_OFS: prdata <= {28'h0, cmd_pend, cmd_op};
        `UOH_CFG_OFS: prdata <= {6'h0, bulk_count, 2'h0, bulk_toggle, bulk_endpoint,
                                 nak_retry_disable, low_speed_select, target_addr};
        `UOH_BUF_OFS: prdata <= descriptor_buffer_pointer;
        `UOH_STAT_OFS: prdata <= {19'h0, frame_used, last_pid, 1'b0, aborted,
                                  sesvalid_seen, sesend_seen, attach_seen, detach_seen,
                                  done_flag, running | cmd_pend};
        default: prdata <= 32'h0;
      endcase
    end
  end

  // Frame timer; a control transaction spends the frame it starts in
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_cnt <= 24'h0;
      frame_used <= 1'b0;
    end else begin
      frame_cnt <= frame_tick ? FRAME_CYC - 24'h1 : frame_cnt - 24'h1;
      if (state == ST_IDLE && cmd_pend && ctl_op && !frame_used) begin
        frame_used <= 1'b1;
      end else if (frame_tick) begin
        frame_used <= 1'b0;
      end
    end
  end

  // Sequencer: runs orders, otherwise keeps watching the event flags
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      op <= `UOH_OP_WATCH;
      seq <= 4'h0;
      running <= 1'b0;
      clr_phase <= 1'b0;
      tmr <= 24'h0;
      mst_start <= 1'b0;
      mst_addr <= 12'h0;
      mst_write <= 1'b0;
      mst_wdata <= 32'h0;
      done_flag <= 1'b0;
      detach_seen <= 1'b0;
      attach_seen <= 1'b0;
      sesend_seen <= 1'b0;
      sesvalid_seen <= 1'b0;
      aborted <= 1'b0;
      last_pid <= 4'h0;
    end else begin
      mst_start <= 1'b0;
      // Software clears sticky bits by writing one; hardware sets win below
      if (wr_en && paddr == `UOH_STAT_OFS) begin
        if (pwdata[1]) done_flag <= 1'b0;
        if (pwdata[2]) detach_seen <= 1'b0;
        if (pwdata[3]) attach_seen <= 1'b0;
        if (pwdata[4]) sesend_seen <= 1'b0;
        if (pwdata[5]) sesvalid_seen <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          seq <= 4'h0;
          state <= ST_FETCH;
          if (cmd_pend && !(ctl_op && frame_used)) begin
            op <= cmd_op;
            running <= 1'b1;
            aborted <= 1'b0;
          end else begin
            op <= `UOH_OP_WATCH;
          end
        end
        ST_FETCH: begin
          mst_addr <= r_addr;
          mst_wdata <= {16'h0, r_data};
          mst_write <= (r_act == A_WR);
          case (r_act)
            A_WR, A_POLL, A_BDRD: begin
              mst_start <= 1'b1;
              state <= ST_BUS;
            end
            A_DLY: begin
              tmr <= (r_data[1:0] == 2'd0) ? LINES_LOW_CYC :
                     (r_data[1:0] == 2'd1) ? DPULSE_CYC : VBUS_PULSE_CYC;
              state <= ST_TIME;
            end
            default: begin
              if (running) done_flag <= 1'b1;
              running <= 1'b0;
              state <= ST_IDLE;
            end
          endcase
        end
        ST_BUS: begin
          if (mst_done) begin
            if (clr_phase) begin
              // Flags just cleared by writing ones back
              clr_phase <= 1'b0;
              seq <= aborted ? 4'hf : seq + 4'h1;
              state <= ST_FETCH;
            end else if (r_act == A_POLL) begin
              if (r_addr == `UOH_DEV_TOP_FLAGS) begin
                if (masked[0]) detach_seen <= 1'b1;
                if (masked[6]) attach_seen <= 1'b1;
                if (masked[0] && op != `UOH_OP_WATCH) begin
                  aborted <= 1'b1;
                  last_pid <= `UOH_PID_ERROR;
                end
              end else begin
                if (masked[2]) sesend_seen <= 1'b1;
                if (masked[3]) sesvalid_seen <= 1'b1;
              end
              if (masked != 8'h0) begin
                clr_phase <= 1'b1;
                mst_write <= 1'b1;
                mst_wdata <= {24'h0, masked};
                mst_start <= 1'b1;
              end else begin
                // Waiting polls repeat until their flag shows up
                seq <= r_data[0] ? seq : seq + 4'h1;
                state <= ST_FETCH;
              end
            end else begin
              if (r_act == A_BDRD) begin
                last_pid <= mst_rdata[`UOH_BD_PID_LSB +: 4];
              end
              seq <= seq + 4'h1;
              state <= ST_FETCH;
            end
          end
        end
        ST_TIME: begin
          // VBUS is deliberately not looked at during a pulse
          if (tmr <= 24'h1) begin
            seq <= seq + 4'h1;
            state <= ST_FETCH;
          end else begin
            tmr <= tmr - 24'h1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // One transfer at a time on the module's register port
  uoh_dev_master u_master (
    .pclk(pclk),
    .presetn(presetn),
    .start(mst_start),
    .addr(mst_addr),
    .write(mst_write),
    .wdata(mst_wdata),
    .done(mst_done),
    .rdata(mst_rdata),
    .m_psel(m_psel),
    .m_penable(m_penable),
    .m_pwrite(m_pwrite),
    .m_paddr(m_paddr),
    .m_pwdata(m_pwdata),
    .m_prdata(m_prdata),
    .m_pready(m_pready)
  );

endmodule // uoh_host_seq

// File: verification/uoh_host_seq_assertions.sv
/* Port checker for the host sequencer.
   Assumes it is bound to uoh_host_seq and sees only its ports. */
`include "uoh_defines.vh"
module uoh_host_seq_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire m_psel,
  input wire m_penable,
  input wire m_pwrite,
  input wire [11:0] m_paddr,
  input wire [31:0] m_pwdata,
  input wire m_pready
);
  timeunit 1ns;
  timeprecision 1ps;
  // Write access phase on the module port
  wire wacc = m_psel && m_penable && m_pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_ZERO_WAIT: assert property (psel && penable |-> pready) else $error("slave stalled");
  AST_UNMAPPED: assert property (psel && penable && paddr[1:0] == 2'h0
    |-> pslverr == (paddr > `UOH_STAT_OFS)) else $error("bad pslverr");
  AST_SETUP_FIRST: assert property ($rose(m_psel) |-> !m_penable ##1 m_penable)
    else $error("no setup");
  AST_HOLD: assert property (m_psel && m_penable && !m_pready |=> m_penable
    && $stable(m_paddr) && $stable(m_pwdata) && $stable(m_pwrite)) else $error("request moved");
  AST_RELEASE: assert property (m_penable && m_pready |=> !m_penable && !m_psel)
    else $error("no release");
  AST_TOKEN_CODE: assert property (
    wacc && m_paddr == `UOH_DEV_TOKEN |-> m_pwdata[3:0] == 4'h1
    || m_pwdata[7:0] inside {8'hd0, 8'h90}) else $error("bad token code");
  AST_EP0_CODE: assert property (
    wacc && m_paddr == `UOH_DEV_EP_ZERO |-> m_pwdata[5:0] inside {6'h0d, 6'h1d})
    else $error("bad ep0");
  AST_BD_OWN: assert property (
    wacc && m_paddr == `UOH_DEV_BD_STAT |-> m_pwdata[15]) else $error("bd not owned");
  AST_TARGET: assert property (
    wacc && m_paddr == `UOH_DEV_TARGET |-> m_pwdata[31:8] == 24'h0) else $error("wide target");
endmodule // uoh_host_seq_chk
bind uoh_host_seq uoh_host_seq_chk uoh_host_seq_chk_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .m_psel(m_psel), .m_penable(m_penable), .m_pwrite(m_pwrite), .m_paddr(m_paddr),
  .m_pwdata(m_pwdata), .m_pready(m_pready));

// File: verification/uoh_usb_model.sv
/* Behavioural USB module register port with a device answer.
   Assumes an APB master on the same clock. */
`include "uoh_defines.vh"
module uoh_usb_model (
  input wire pclk,
  input wire presetn,
  input wire m_psel,
  input wire m_penable,
  input wire m_pwrite,
  input wire [11:0] m_paddr,
  input wire [31:0] m_pwdata,
  output logic [31:0] m_prdata,
  output logic m_pready,
  input wire slow,
  input wire [3:0] hs_pid,
  input wire detach_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] top, otg, otgcon, cfg2, ep0, target, token, run, tok_cnt;
  logic [15:0] bdstat, bd_set;
  logic [31:0] cyc, tok_cyc, tok_gap, dp_start, dp_len;
  logic [39:0] otg_log;
  logic waited;
  wire wr = m_psel && m_penable && m_pwrite && m_pready;
  // Slow mode inserts one wait state per access
  assign m_pready = m_psel && m_penable && (!slow || waited);
  // Unselected bus shows a moving pattern, never the last value
  always_comb begin
    m_prdata = ~cyc;
    if (m_psel) begin
      case (m_paddr)
        `UOH_DEV_OTG_FLAGS: m_prdata = {24'h0, otg};
        `UOH_DEV_TOP_FLAGS: m_prdata = {24'h0, top};
        `UOH_DEV_BD_STAT: m_prdata = {16'h0, bdstat};
        default: m_prdata = 32'h0;
      endcase
    end
  end
  // Register writes and the token engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {top, otg, otgcon, cfg2, ep0, target, token, run, tok_cnt} <= '0;
      {bdstat, bd_set, cyc, tok_cyc, tok_gap, dp_start, dp_len, otg_log, waited} <= '0;
    end else begin
      cyc <= cyc + 32'h1;
      waited <= m_penable && !m_pready;
      if (run != 8'h0) run <= run - 8'h1;
      if (wr) begin
        case (m_paddr)
          `UOH_DEV_TOP_FLAGS: top <= top & ~m_pwdata[7:0];
          `UOH_DEV_OTG_FLAGS: otg <= otg & ~m_pwdata[7:0];
          `UOH_DEV_OTG_CON: begin
            otgcon <= m_pwdata[7:0];
            otg_log <= {otg_log[31:0], m_pwdata[7:0]};
            if (m_pwdata[0]) otg[2] <= 1'b1;
            if (!otgcon[7] && m_pwdata[7]) dp_start <= cyc;
            if (otgcon[7] && !m_pwdata[7]) dp_len <= cyc - dp_start;
          end
          `UOH_DEV_CFG_TWO: begin
            cfg2 <= m_pwdata[7:0];
            if (cfg2[4] && !m_pwdata[4]) otg[3] <= 1'b1;
          end
          `UOH_DEV_EP_ZERO: ep0 <= m_pwdata[7:0];
          `UOH_DEV_TARGET: target <= m_pwdata[7:0];
          `UOH_DEV_BD_STAT: begin
            bdstat <= m_pwdata[15:0];
            bd_set <= m_pwdata[15:0];
          end
          `UOH_DEV_TOKEN: if (run == 8'h0) begin
            token <= m_pwdata[7:0];
            run <= 8'd20;
            tok_cnt <= tok_cnt + 8'h1;
            // Frames counted as the bench's 200-cycle frame timer
            tok_gap <= cyc / 200 - tok_cyc / 200;
            tok_cyc <= cyc;
          end
          default: ;
        endcase
      end
      // Completion after a fixed bus time; set wins over a same-cycle clear
      if (run == 8'h1) begin
        if (detach_mode) top[0] <= 1'b1;
        else begin
          // NAK with retry enabled is resent until the device takes it
          bdstat <= {2'b00, bdstat[13:6], (ep0[6] || hs_pid != 4'ha) ? hs_pid : 4'h2,
            2'b00};
          top[3] <= 1'b1;
        end
      end
    end
  end
endmodule // uoh_usb_model

// File: verification/uoh_host_seq_tb.sv
/* Self-checking bench of the host sequencer with a USB module model.
   Assumes short timing parameters so the whole run stays brief. */
`include "uoh_defines.vh"
module uoh_host_seq_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd, st;
  wire [31:0] prdata, m_prdata, m_pwdata;
  wire pready, pslverr, m_psel, m_penable, m_pwrite, m_pready;
  wire [11:0] m_paddr;
  logic slow = 0, detach_mode = 0;
  logic [3:0] hs_pid = 4'h2;
  logic [3:0] codes [4] = '{4'h2, 4'ha, 4'he, 4'hf};
  int err_count = 0, cmp_count = 0;
  always #25 pclk = ~pclk;
  uoh_host_seq #(.FRAME_CYC(24'd200), .LINES_LOW_CYC(24'd50), .DPULSE_CYC(24'd50),
    .VBUS_PULSE_CYC(24'd50)) uoh_host_seq_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .m_psel(m_psel),
    .m_penable(m_penable), .m_pwrite(m_pwrite), .m_paddr(m_paddr), .m_pwdata(m_pwdata),
    .m_prdata(m_prdata), .m_pready(m_pready));
  uoh_usb_model uoh_usb_model_inst (.pclk(pclk), .presetn(presetn), .m_psel(m_psel),
    .m_penable(m_penable), .m_pwrite(m_pwrite), .m_paddr(m_paddr), .m_pwdata(m_pwdata),
    .m_prdata(m_prdata), .m_pready(m_pready), .slow(slow), .hs_pid(hs_pid),
    .detach_mode(detach_mode));
  task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One APB transfer held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Order, poll done, keep status, clear
  task automatic run_op(input logic [2:0] op, input logic dup);
    apb(1'b1, `UOH_CMD_OFS, {29'h0, op});
    if (dup) apb(1'b1, `UOH_CMD_OFS, 32'h1);
    rd = 0;
    while (rd[1] !== 1'b1) apb(1'b0, `UOH_STAT_OFS, 32'h0);
    st = rd;
    apb(1'b1, `UOH_STAT_OFS, 32'h2);
    $display("operation %0d finished", op);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `UOH_STAT_OFS, 32'h0);
    chk("stat_reset", 0, rd);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped_err", 1, err);
    apb(1'b1, `UOH_CFG_OFS, 32'h5);
    run_op(`UOH_OP_SETUP, 1'b0);
    chk("setup_pid", 2, st[11:8]);
    chk("ep0", 8'h0d, uoh_usb_model_inst.ep0);
    chk("bd_setup", 16'h8008, uoh_usb_model_inst.bd_set);
    chk("target", 8'h05, uoh_usb_model_inst.target);
    chk("tok_setup", 8'hd0, uoh_usb_model_inst.token);
    chk("top_clear", 0, uoh_usb_model_inst.top);
    run_op(`UOH_OP_IN, 1'b0);
    chk("tok_in", 8'h90, uoh_usb_model_inst.token);
    chk("bd_in", 16'hc040, uoh_usb_model_inst.bd_set);
    chk("frame_gap", 1, uoh_usb_model_inst.tok_gap >= 1);
    run_op(`UOH_OP_STATUS, 1'b1);
    chk("tok_status", 8'h01, uoh_usb_model_inst.token);
    chk("bd_status", 16'h8000, uoh_usb_model_inst.bd_set);
    chk("tok_count", 3, uoh_usb_model_inst.tok_cnt);
    for (int i = 0; i < 4; i++) begin
      hs_pid <= codes[i];
      slow <= i[0];
      apb(1'b1, `UOH_CFG_OFS, 32'h785);
      run_op(`UOH_OP_BULK, 1'b0);
      chk("bulk_pid", codes[i], st[11:8]);
    end
    chk("tok_bulk", 8'h31, uoh_usb_model_inst.token);
    chk("ep0_bulk", 8'hdd, uoh_usb_model_inst.ep0);
    chk("target_ls", 8'h85, uoh_usb_model_inst.target);
    hs_pid <= 4'ha;
    apb(1'b1, `UOH_CFG_OFS, 32'h605);
    run_op(`UOH_OP_BULK, 1'b0);
    chk("retry_pid", 2, st[11:8]);
    detach_mode <= 1'b1;
    run_op(`UOH_OP_SETUP, 1'b0);
    chk("detach", 6'h3f, {st[11:8], st[6], st[2]});
    apb(1'b1, `UOH_STAT_OFS, 32'h4);
    apb(1'b0, `UOH_STAT_OFS, 32'h0);
    chk("detach_w1c", 0, rd[2]);
    detach_mode <= 1'b0;
    run_op(`UOH_OP_SRP, 1'b0);
    chk("otg_seq", 40'h0100800080, uoh_usb_model_inst.otg_log);
    chk("dplus_len", 1, uoh_usb_model_inst.dp_len >= 50);
    chk("otg_clear", 0, uoh_usb_model_inst.otg);
    report_and_stop;
  end
  // Watchdog
  initial begin
    repeat (100000) @(posedge pclk);
    err_count++;
    report_and_stop;
  end
endmodule // uoh_host_seq_tb
